// file: hw/boost_led_fault_protection.sv
// Fault supervisor for a boost LED driver: OVERVOLTAGE_SENSE_PIN, switch limits, input disconnect,
// undervoltage lockout and long-low shutdown. Analog comparators arrive asynchronous;
// osc_tick_i is a same-domain strobe, one per switching cycle.
// Overview of operation
// - Output overvoltage inhibits switching while tripped
// - Switching resumes once overvoltage comparator releases
// - Open string causing overvoltage is dropped
// - Switch node overvoltage shuts down and latches
// - Latched fault cleared only by full shutdown
// - String detection precedes boost enable at start
// - Cycle-by-cycle limit ends on-time this cycle
// - Secondary switch limit shuts down immediately
// - 1x input current flags fault, timed regulation
// - 1x condition gone early clears fault flag
// - Sync pin low over 7 us forces shutdown
// - 2x input current latches shutdown within 3 us
// - Enable only after supply and sense rise
// - Disable after supply low over 50 us
// - Long enable low enters shutdown, clears state
// - Shutdown keeps sinks off until enable high
// - Long-low shutdown clears latched faults
`timescale 1ns/1ps
`include "boost_led_fault_params.svh"
`default_nettype none
module boost_led_fault_protection #(
  parameter int CC_CYCLES   = `CC_TIMER_OSC_CYCLES,
  parameter int SHDN_CYCLES = `SHUTDOWN_LOW_OSC,
  parameter int UV_CYCLES   = `UV_DEGLITCH_CYCLES,
  parameter int STRINGS     = `STRING_COUNT
) (
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       clk_en_i,
  input  wire logic                       osc_tick_i,
  input  wire boost_led_fault_pkg::sense_t sense_i,
  input  wire logic [STRINGS-1:0]         string_open_i,
  input  wire logic                       dim_en_i,
  input  wire logic                       freq_set_sync_pin_i,
  output logic                            boost_gate_o,
  output logic                            disc_on_o,
  output logic                            disc_cc_mode_o,
  output logic [STRINGS-1:0]              sink_en_o,
  output logic                            fault_n_o
);
  import boost_led_fault_pkg::*;

  // Refuse counts that the 16-bit saturating timers cannot hold
  if (STRINGS < 1 || CC_CYCLES < 2 || SHDN_CYCLES < 2 || UV_CYCLES < 2
      || CC_CYCLES > 32'h0000FFFE || SHDN_CYCLES > 32'h0000FFFE || UV_CYCLES > 32'h0000FFFE)
  begin : g_bad_params
    $error("Timer or string count out of range");
  end

  localparam int SYNC_CYC = `SYNC_LOW_CYCLES;

  // Two-stage synchronisers for all asynchronous inputs
  localparam int NS = 9 + STRINGS + 2;
  logic [NS-1:0] s1_q, s2_q;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else if (clk_en_i)
    begin
      s1_q <= {sense_i, string_open_i, dim_en_i, freq_set_sync_pin_i};
      s2_q <= s1_q;
    end
  end
  sense_t             sn;
  logic [STRINGS-1:0] open_s;
  logic               en_s, sync_s;
  assign {sn, open_s, en_s, sync_s} = s2_q;

  // Saturating counter step
  function automatic logic [15:0] step(input logic [15:0] c, input logic run,
                                       input logic inc, input logic [15:0] lim);
    step = !run ? 16'h0000 : ((inc && c < lim) ? c + 16'h0001 : c);
  endfunction

  state_t             st_q, st_d;
  logic [15:0]        cc_q, cc_d, lo_q, lo_d, uv_q, uv_d, sy_q, sy_d;
  logic [STRINGS-1:0] drop_q, drop_d;
  logic               latch_q, latch_d, pwr_q, pwr_d;
  logic               gate_q, gate_d, disc_q, disc_d, ccm_q, ccm_d, flt_q, flt_d;
  logic [STRINGS-1:0] sink_q, sink_d;
  logic               long_low, sync_kill, hard_fault, shdn;

  // Next state of supervisor and timers
  always_comb
  begin
    cc_d = step(cc_q, sn.in_1x && !sn.in_2x, osc_tick_i, 16'(CC_CYCLES));
    lo_d = step(lo_q, !en_s, osc_tick_i, 16'(SHDN_CYCLES));
    uv_d = step(uv_q, sn.uv_fall, 1'b1, 16'(UV_CYCLES));
    sy_d = step(sy_q, !sync_s, 1'b1, 16'(SYNC_CYC));
    long_low  = lo_q >= 16'(SHDN_CYCLES);
    sync_kill = sy_q >= 16'(SYNC_CYC);
    hard_fault = sn.sw_ovp || sn.ilim2 || sn.in_2x
               || (cc_q >= 16'(CC_CYCLES));
    // Power good: rise on both inputs, fall only after deglitch or hard drop
    pwr_d = pwr_q;
    if (!pwr_q && sn.uv_rise_ok)
      pwr_d = 1'b1;
    if (sn.uv_hard || uv_q >= 16'(UV_CYCLES))
      pwr_d = 1'b0;
    shdn = !pwr_q || long_low;
    latch_d = shdn ? 1'b0 : (latch_q || (st_q != ST_OFF && st_q != ST_DETECT
                                          && hard_fault));
    drop_d = drop_q;
    st_d   = st_q;
    unique case (st_q)
      ST_OFF:
        if (pwr_q && en_s && !sync_kill)
          st_d = ST_DETECT;
      ST_DETECT:
      begin
        drop_d = open_s;
        if (sync_kill)
          st_d = ST_STOP;
        else
          st_d = ST_RUN;
      end
      ST_RUN:
        if (latch_d)
          st_d = ST_LATCH;
        else if (sync_kill)
          st_d = ST_STOP;
        else if (sn.ovp_trip)
          drop_d = drop_q | open_s;
      ST_LATCH, ST_STOP:
        if (!sync_kill && st_q == ST_STOP && en_s)
          st_d = ST_RUN;
      default:
        st_d = ST_OFF;
    endcase
    if (shdn)
    begin
      st_d   = ST_OFF;
      drop_d = '0;
    end
    // Outputs
    gate_d = st_d == ST_RUN && en_s && !sn.ovp_trip && !sn.ilim1;
    disc_d = st_d == ST_RUN || st_d == ST_DETECT;
    ccm_d  = disc_d && sn.in_1x && !sn.in_2x;
    sink_d = (st_d == ST_RUN && en_s) ? ~drop_d : '0;
    flt_d  = !(latch_d || (disc_d && sn.in_1x));
  end

  // Register all state
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q    <= ST_OFF;
      cc_q    <= 16'h0000;
      lo_q    <= 16'h0000;
      uv_q    <= 16'h0000;
      sy_q    <= 16'h0000;
      drop_q  <= '0;
      latch_q <= 1'b0;
      pwr_q   <= 1'b0;
      gate_q  <= 1'b0;
      disc_q  <= 1'b0;
      ccm_q   <= 1'b0;
      sink_q  <= '0;
      flt_q   <= 1'b1;
    end
    else if (clk_en_i)
    begin
      st_q    <= st_d;
      cc_q    <= cc_d;
      lo_q    <= lo_d;
      uv_q    <= uv_d;
      sy_q    <= sy_d;
      drop_q  <= drop_d;
      latch_q <= latch_d;
      pwr_q   <= pwr_d;
      gate_q  <= gate_d;
      disc_q  <= disc_d;
      ccm_q   <= ccm_d;
      sink_q  <= sink_d;
      flt_q   <= flt_d;
    end
  end

  assign boost_gate_o   = gate_q;
  assign disc_on_o      = disc_q;
  assign disc_cc_mode_o = ccm_q;
  assign sink_en_o      = sink_q;
  assign fault_n_o      = flt_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i || !clk_en_i);
  sequence ovp_seen; sn.ovp_trip; endsequence
  a_ovp_no_gate: assert property (ovp_seen |=> !gate_q) else $error("gate during ovp");
  a_ilim_cut: assert property (sn.ilim1 |=> !gate_q) else $error("gate at limit");
  a_sw_ovp_latch: assert property ((st_q == ST_RUN && sn.sw_ovp && pwr_q && !long_low)
    |=> latch_q && !disc_q) else $error("sw ovp not latched");
  a_latch_hold: assert property ((latch_q && pwr_q && !long_low) |=> latch_q)
    else $error("latch lost");
  a_twox_fast: assert property ((st_q == ST_RUN && sn.in_2x) |-> ##[1:3] !disc_q)
    else $error("2x slow");
  a_flag_1x: assert property ((disc_q && sn.in_1x && pwr_q && !long_low && !sync_kill)
    |=> !fault_n_o) else $error("no flag");
  a_sync_stop: assert property (sync_kill |=> !gate_q && !disc_q && sink_q == '0)
    else $error("sync no stop");
  a_shdn_clear: assert property (long_low |=> !latch_q && sink_q == '0 && st_q == ST_OFF)
    else $error("shutdown no clear");
  a_uv_enable: assert property ($rose(pwr_q) |-> $past(sn.uv_rise_ok)) else $error("early en");
  // Faults seen while running and powered must latch on the next edge
  sequence run_twox;
    st_q == ST_RUN && sn.in_2x && pwr_q && !long_low;
  endsequence
  sequence cc_expired;
    st_q == ST_RUN && cc_q >= 16'(CC_CYCLES) && pwr_q && !long_low;
  endsequence
  a_twox_latch: assert property (run_twox |=> latch_q && !fault_n_o)
    else $error("2x not latched");
  a_cc_expire: assert property (cc_expired |=> latch_q && !disc_q)
    else $error("1x timer not latched");
  a_off_no_gate: assert property ((st_q == ST_OFF) |=> !gate_q) else $error("gate before detect");
endmodule
`default_nettype wire

// file: hw/boost_led_fault_params.svh
// Constants for the boost LED fault supervisor: timing counts and limits.
// Assumes a 50 MHz system clock; oscillator ticks arrive as a same-domain strobe.
`ifndef BOOST_LED_FAULT_PARAMS_SVH
`define BOOST_LED_FAULT_PARAMS_SVH
`define CLK_PERIOD_NS        20
`define SYNC_LOW_MIN_NS      7000
`define SYNC_LOW_CYCLES      ((`SYNC_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UV_DEGLITCH_NS       50000
`define UV_DEGLITCH_CYCLES   ((`UV_DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIP2X_MAX_NS        3000
`define TRIP2X_MAX_CYCLES    (`TRIP2X_MAX_NS / `CLK_PERIOD_NS)
`define CC_TIMER_OSC_CYCLES  10000
`define SHUTDOWN_LOW_OSC     32750
`define STRING_COUNT         4
`endif

// file: hw/boost_led_fault_pkg.sv
// Types shared by the boost LED fault supervisor.
// Assumes the params header is compiled alongside.
package boost_led_fault_pkg;
  typedef struct packed {
    logic ovp_trip;        // Output overvoltage comparator
    logic sw_ovp;          // Switch node above safe level
    logic ilim1;           // Cycle-by-cycle switch limit
    logic ilim2;           // Secondary switch limit
    logic in_1x;           // Input current above 1x
    logic in_2x;           // Input current above 2x
    logic uv_rise_ok;      // Supply and sense above rising threshold
    logic uv_fall;         // Supply below falling threshold
    logic uv_hard;         // Supply below hard shutdown level
  } sense_t;
  typedef struct packed {
    logic boost_en;
    logic disc_on;
    logic cc_mode;
    logic fault_n;
  } drive_t;
  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_DETECT = 5'h02,
    ST_RUN    = 5'h04,
    ST_LATCH  = 5'h08,
    ST_STOP   = 5'h10
  } state_t;
endpackage

// file: test/host_model.sv
// Host controller model: drives dimming/enable and sync pins.
// Assumes tb supplies requests; pins change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk_i,
  input  wire logic en_req_i,
  input  wire logic kill_req_i,
  output logic      dim_en_o,
  output logic      sync_o
);
  // Pin levels, idle before the first edge
  logic en_q   = 1'b0;
  logic sync_q = 1'b1;
  // Hold enable low long enough, or sync low for a kill
  always @(negedge clk_i)
  begin
    en_q   <= en_req_i;
    sync_q <= ~kill_req_i;
  end
  assign dim_en_o = en_q;
  assign sync_o   = sync_q;
endmodule
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the boost LED fault supervisor.
// Assumes the design's params header and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import boost_led_fault_pkg::*;
  logic clk, rst_n, en_req, kill_req, dim_en, sync;
  logic tick   = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] open_s, sinks;
  logic [7:0] obs;
  logic gate, disc, ccm, fault_n;
  sense_t sense;
  logic [31:0] seed = 32'hAA347163;
  int failures = 0, comparisons = 0, cyc = 0;
  boost_led_fault_protection #(.CC_CYCLES(20), .SHDN_CYCLES(40), .UV_CYCLES(10)) DUT (
    .clk_i(clk), .arst_n_i(rst_n), .clk_en_i(clk_en), .osc_tick_i(tick), .sense_i(sense),
    .string_open_i(open_s), .dim_en_i(dim_en), .freq_set_sync_pin_i(sync),
    .boost_gate_o(gate), .disc_on_o(disc), .disc_cc_mode_o(ccm), .sink_en_o(sinks),
    .fault_n_o(fault_n));
  host_model host (.clk_i(clk), .en_req_i(en_req), .kill_req_i(kill_req),
    .dim_en_o(dim_en), .sync_o(sync));
  assign obs = {gate, disc, ccm, fault_n, sinks};
  // Clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected outputs: gate, disconnect, cc mode, fault_n, sinks of good strings
  function automatic logic [7:0] expf(input logic [3:0] gdcf, input logic on);
    return {gdcf, on ? ~open_s : 4'h0};
  endfunction
  // Random oscillator ticks; timeout watch
  always @(negedge clk)
  begin
    seed = lfsr(seed);
    tick <= seed[0];
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end
  task automatic run(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] m);
    comparisons++;
    if (((obs ^ e) & m) !== 8'h00)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e & m, obs & m);
    end
  endtask
  // Long enable low, then enable again
  task automatic long_low();
    en_req = 1'b0;
    run(200);
    chk("shutdown sinks", 8'h00, 8'hCF);
    en_req = 1'b1;
    run(12);
    chk("restart", expf(4'hD, 1'b1), 8'hFF);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    en_req = 1'b0;
    kill_req = 1'b0;
    sense = '0;
    open_s = seed[3:0] & 4'h5;
    run(20);
    rst_n = 1'b1;
    run(8);
    chk("no power", 8'h00, 8'hCF);
    sense.uv_rise_ok = 1'b1;
    en_req = 1'b1;
    run(12);
    chk("startup", expf(4'hD, 1'b1), 8'hFF);
    $display("test startup done");
    // Frozen clock enable hides an overvoltage pulse
    clk_en = 1'b0;
    sense.ovp_trip = 1'b1;
    run(6);
    chk("freeze", expf(4'hD, 1'b1), 8'hFF);
    sense.ovp_trip = 1'b0;
    run(2);
    clk_en = 1'b1;
    run(2);
    // A string opens together with the overvoltage trip
    open_s = open_s | 4'h2;
    sense.ovp_trip = 1'b1;
    run(6);
    chk("ovp stop", expf(4'h5, 1'b1), 8'hFF);
    sense.ovp_trip = 1'b0;
    run(6);
    chk("ovp resume", expf(4'hD, 1'b1), 8'hFF);
    sense.ilim1 = 1'b1;
    run(5);
    chk("ilim cut", expf(4'h5, 1'b1), 8'hFF);
    sense.ilim1 = 1'b0;
    run(5);
    chk("ilim next", expf(4'hD, 1'b1), 8'hFF);
    sense.in_1x = 1'b1;
    run(5);
    chk("1x flag", expf(4'hE, 1'b1), 8'hFF);
    sense.in_1x = 1'b0;
    run(6);
    chk("1x clear", expf(4'hD, 1'b1), 8'hFF);
    $display("test ovp and 1x done");
    // Latched faults: switch node, secondary limit, 2x input, expired 1x timer
    for (int i = 0; i < 4; i++)
    begin
      sense.sw_ovp = (i == 0);
      sense.ilim2 = (i == 1);
      sense.in_2x = (i == 2);
      sense.in_1x = (i == 3);
      run((i == 3) ? 80 : 2);
      sense = '0;
      sense.uv_rise_ok = 1'b1;
      run(6);
      chk("latched", 8'h00, 8'hDF);
      run(30);
      chk("still latched", 8'h00, 8'hDF);
      long_low();
    end
    $display("test latched faults done");
    kill_req = 1'b1;
    run(370);
    chk("sync kill", 8'h00, 8'hCF);
    kill_req = 1'b0;
    run(12);
    chk("after kill", expf(4'hD, 1'b1), 8'hFF);
    rst_n = 1'b0;
    run(2);
    chk("mid reset", 8'h10, 8'hFF);
    rst_n = 1'b1;
    run(12);
    chk("after reset", expf(4'hD, 1'b1), 8'hFF);
    sense.uv_fall = 1'b1;
    run(5);
    sense.uv_fall = 1'b0;
    run(6);
    chk("uv glitch", expf(4'hD, 1'b1), 8'hFF);
    sense.uv_hard = 1'b1;
    run(5);
    chk("uv hard", 8'h00, 8'hCF);
    sense.uv_hard = 1'b0;
    run(12);
    chk("uv recover", expf(4'hD, 1'b1), 8'hFF);
    sense.uv_fall = 1'b1;
    sense.uv_rise_ok = 1'b0;
    run(25);
    chk("uv off", 8'h00, 8'hCF);
    $display("test sync and uvlo done");
    summarize();
  end
endmodule
`default_nettype wire
